// ===== bench/tsl_host_model.sv
`timescale 1ns/1ps
// Host reading the code lines; floated lines read back inverted every cycle
module tsl_host_model (
  // Clock
  input wire logic clock_in,
  // Device side
  input wire logic digit_valid_flag_in,
  input wire logic [3:0] digit_code_bus_in,
  input wire logic digit_code_oe_in,
  // Bench side
  input wire logic read_enable_in,
  output logic code_output_enable_out,
  output logic got_out,
  output logic [3:0] code_out
);
  logic valid_q;
  logic oe_q;
  logic [3:0] wire_q;
  wire [3:0] line_w = digit_code_oe_in ? digit_code_bus_in : ~wire_q;
  wire rise_w = digit_valid_flag_in && !valid_q;
  always_ff @(posedge clock_in) begin
    valid_q <= digit_valid_flag_in;
    oe_q <= digit_code_oe_in;
    wire_q <= line_w;
    code_output_enable_out <= read_enable_in;
    got_out <= (rise_w && digit_code_oe_in) || (digit_code_oe_in && !oe_q && digit_valid_flag_in);
    // Code taken from the cycle before the flag rose, so it must already be settled
    code_out <= rise_w ? wire_q : line_w;
  end
endmodule

// ===== bench/tsl_steering_latch_tb.sv
`timescale 1ns/1ps
module tsl_steering_latch_tb;
  logic clock_in = 0;
  logic rst_in = 1;
  logic tone_detect_in = 1;
  logic [3:0] tone_code_in = 4'h0;
  logic power_down_in = 0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_wr_in = 0;
  logic reg_rd_in = 0;
  logic read_en = 1;
  logic rd_q = 0;
  logic valid_d = 0;
  logic code_output_enable, early, valid, oe, irq, sg_out, sg_oe, got;
  logic [3:0] code, host_code;
  logic [15:0] rdata;
  logic [15:0] rq[$];
  logic [3:0] dq[$];
  int err_total = 0;
  int compares = 0;
  int falls = 0;
  always #10 clock_in = ~clock_in;
  // Short counts keep the run brief; expectations scale from these
  tsl_steering_latch #(.DET_CYC(8), .ABS_CYC(4), .PWRUP_CYC(16), .TICK_CYC(4)) u_tsl_steering_latch (
    .clock_in(clock_in), .rst_in(rst_in), .tone_detect_in(tone_detect_in), .tone_code_in(tone_code_in),
    .power_down_in(power_down_in), .steer_guard_in(sg_oe ? sg_out : 1'b0), .steer_guard_out(sg_out),
    .steer_guard_oe_out(sg_oe), .code_output_enable_in(code_output_enable), .early_tone_flag_out(early),
    .digit_valid_flag_out(valid), .digit_code_bus_out(code), .digit_code_oe_out(oe),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata), .irq_out(irq));
  tsl_host_model u_tsl_host_model (
    .clock_in(clock_in), .digit_valid_flag_in(valid), .digit_code_bus_in(code), .digit_code_oe_in(oe),
    .read_enable_in(read_en), .code_output_enable_out(code_output_enable), .got_out(got), .code_out(host_code));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_rd(input logic [15:0] g, input logic [15:0] e);
    chk(g, e);
  endtask

  task automatic chk_code(input logic [3:0] g, input logic [3:0] e);
    chk(16'(g), 16'(e));
  endtask

  task automatic end_sim();
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Read pushes its expected word; write ignores the queue
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    if (w) reg_wr_in <= 1;
    else begin
      reg_rd_in <= 1;
      rq.push_back(d);
    end
    @(posedge clock_in);
    reg_wr_in <= 0;
    reg_rd_in <= 0;
  endtask

  task automatic wait_valid(input logic lvl, output int n);
    for (n = 0; n < 300 && valid !== lvl; n++) @(posedge clock_in);
    if (valid !== lvl) begin
      err_total++;
      end_sim();
    end
  endtask

  always @(posedge clock_in) begin
    if (rd_q) chk_rd(rdata, rq.pop_front());
    else if (!rst_in && rdata !== 16'h0000) chk_rd(rdata, 16'h0000);
    if (got === 1'b1) chk_code(host_code, dq.pop_front());
    if (valid_d === 1'b1 && valid === 1'b0) falls++;
    rd_q <= reg_rd_in;
    valid_d <= valid;
  end

  initial begin
    logic [3:0] c;
    int f;
    int n;
    void'($urandom(32'h51c4));
    repeat (6) @(posedge clock_in);
    rst_in <= 0;
    // Tone present across reset release: early flag waits for power-up
    repeat (12) @(posedge clock_in);
    chk(16'(early), 16'h0000);
    for (f = 0; f < 40 && early !== 1'b1; f++) @(posedge clock_in);
    chk(16'(early), 16'h0001);
    tone_detect_in <= 0;
    repeat (30) @(posedge clock_in);
    chk({11'h0, valid, code}, 16'h0000);
    reg_op(0, 8'h04, 16'h00FA);
    reg_op(0, 8'h08, 16'h0096);
    reg_op(0, 8'h10, 16'h0000);
    reg_op(0, 8'h20, 16'h0000);
    reg_op(0, 8'h0C, 16'h000C);
    reg_op(1, 8'h0C, 16'h000F);
    reg_op(0, 8'h0C, 16'h0000);
    reg_op(1, 8'h04, 16'h0005);
    reg_op(1, 8'h08, 16'h000A);
    reg_op(1, 8'h10, 16'h0001);
    for (f = 0; f < 3; f++) begin
      c = 4'($urandom);
      dq.push_back(c);
      @(posedge clock_in);
      tone_detect_in <= 1;
      tone_code_in <= c;
      wait_valid(1, n);
      chk(16'(n >= 28), 16'h0001);
      @(posedge clock_in);
      chk(16'(irq), 16'h0001);
      reg_op(1, 8'h0C, 16'h0001);
      repeat (2) @(posedge clock_in);
      chk(16'(irq), 16'h0000);
      if (f == 2) begin
        // Dropout well under the absent guard
        tone_detect_in <= 0;
        repeat (10) @(posedge clock_in);
        tone_detect_in <= 1;
        repeat (30) @(posedge clock_in);
        chk(16'(valid), 16'h0001);
      end
      repeat (20) @(posedge clock_in);
      tone_detect_in <= 0;
      wait_valid(0, n);
      chk(16'(n >= 46), 16'h0001);
      repeat (30) @(posedge clock_in);
      chk({11'h0, valid, code}, 16'(c));
    end
    chk(16'(falls), 16'h0003);
    // Code lines floated while a new digit latches
    read_en <= 0;
    repeat (8) @(posedge clock_in);
    chk(16'(oe), 16'h0000);
    c = ~c;
    dq.push_back(c);
    tone_detect_in <= 1;
    tone_code_in <= c;
    wait_valid(1, n);
    read_en <= 1;
    repeat (10) @(posedge clock_in);
    chk(16'(oe), 16'h0001);
    tone_detect_in <= 0;
    wait_valid(0, n);
    // Burst too short for the present guard
    tone_code_in <= ~c;
    tone_detect_in <= 1;
    repeat (14) @(posedge clock_in);
    tone_detect_in <= 0;
    repeat (40) @(posedge clock_in);
    chk({11'h0, valid, code}, 16'(c));
    reg_op(0, 8'h0C, 16'h000F);
    // Guard pin looped back; tone applied while powered down
    reg_op(1, 8'h00, 16'h0001);
    reg_op(0, 8'h00, 16'h0001);
    c = 4'($urandom);
    dq.push_back(c);
    power_down_in <= 1;
    tone_code_in <= c;
    tone_detect_in <= 1;
    repeat (30) @(posedge clock_in);
    chk({14'h0, early, valid}, 16'h0000);
    power_down_in <= 0;
    wait_valid(1, n);
    chk(16'(n >= 18), 16'h0001);
    chk({14'h0, sg_oe, sg_out}, 16'h0003);
    tone_detect_in <= 0;
    wait_valid(0, n);
    reg_op(0, 8'h14, {8'h01, 4'h9, c});
    repeat (5) @(posedge clock_in);
    end_sim();
  end
endmodule

// ===== hdl/tsl_steering_latch.sv
`timescale 1ns/1ps
`include "tsl_consts.svh"
// Function
// - Tone pair recognised no sooner than 5 ms, no later than 14 ms.
// - Tone loss recognised no sooner than 0.5 ms, no later than 8.5 ms.
// - Early flag rises on tone detection, before any guard qualification.
// - Guard times adjustable; defaults accept 40 ms, reject under 20 ms.
// - Tone ending inside present guard leaves code and valid flag alone.
// - Tone lasting the full present guard is latched onto the code outputs.
// - Digit shown as a 4-bit parallel code.
// - After absent guard expires, code holds until the next qualified tone.
// - Valid flag rises after present guard, falls after absent guard.
// - Dropout shorter than absent guard keeps digit and flag latched.
// - Dropout limit is a guard setting; 20 ms gaps end the tone.
// - Output enable low floats the four code lines.
// - Digits latch internally even while code outputs are disabled.
// - Code updates before the valid flag rises.
// - Guard pin is driven out and its returned level judges qualification.
// - After power-down release with tone, early flag rises after 30 ms.
module tsl_steering_latch #(
  parameter int DET_CYC = `TSL_DET_CYC,
  parameter int ABS_CYC = `TSL_ABS_CYC,
  parameter int PWRUP_CYC = `TSL_PWRUP_CYC,
  parameter int TICK_CYC = `TSL_TICK_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Tone detector side
  input wire logic tone_detect_in,
  input wire logic [3:0] tone_code_in,
  input wire logic power_down_in,
  // Guard pin
  input wire logic steer_guard_in,
  output logic steer_guard_out,
  output logic steer_guard_oe_out,
  // Host side
  input wire logic code_output_enable_in,
  output logic early_tone_flag_out,
  output logic digit_valid_flag_out,
  output logic [3:0] digit_code_bus_out,
  output logic digit_code_oe_out,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic irq_out
);

  // Synchronisers: first stage feeds only the second
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  wire logic [7:0] pins_raw = {code_output_enable_in, steer_guard_in, power_down_in,
                               tone_code_in, tone_detect_in};
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end
  wire logic tone_s = sync2_r[0];
  wire logic [3:0] code_s = sync2_r[4:1];
  wire logic pd_s = sync2_r[5];
  wire logic pin_s = sync2_r[6];
  wire logic toe_s = sync2_r[7];

  // Registers
  logic [15:0] ctrl_r;
  logic [15:0] pguard_r;
  logic [15:0] aguard_r;
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic [15:0] rdata_r;
  logic irq_r;

  // Timing state
  logic [12:0] tick_cnt_r;
  logic tick_r;
  logic [20:0] pu_cnt_r;
  logic ready_r;
  logic [20:0] det_cnt_r;
  logic est_r;
  logic [15:0] gcnt_r;
  tsl_pkg::tsl_state_e state_r;
  tsl_pkg::tsl_state_e state_nxt;
  logic [3:0] code_r;
  logic valid_r;
  logic drv_r;
  logic drv_oe_r;
  logic code_oe_r;

  // Address decode
  wire logic sel_ctrl = reg_addr_in == `TSL_REG_CTRL;
  wire logic sel_pguard = reg_addr_in == `TSL_REG_PGUARD;
  wire logic sel_aguard = reg_addr_in == `TSL_REG_AGUARD;
  wire logic sel_status = reg_addr_in == `TSL_REG_STATUS;
  wire logic sel_mask = reg_addr_in == `TSL_REG_MASK;
  wire logic sel_state = reg_addr_in == `TSL_REG_STATE;
  wire logic ext_mode = ctrl_r[`TSL_CTRL_EXT];

  // Slow tick for guard counters, so 16-bit guards reach seconds
  wire logic tick_wrap = tick_cnt_r == 13'(TICK_CYC - 1);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tick_cnt_r <= 13'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? 13'h0000 : tick_cnt_r + 13'h0001;
      tick_r <= tick_wrap;
    end
  end

  // Power-up timer restarts on every power-down
  wire logic pu_done = pu_cnt_r == 21'(PWRUP_CYC - 1);
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pu_cnt_r <= 21'h000000;
      ready_r <= 1'b0;
    end else if (pd_s) begin
      pu_cnt_r <= 21'h000000;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      pu_cnt_r <= pu_cnt_r + 21'h000001;
      ready_r <= pu_done;
    end
  end

  // Presence and absence detection; detector runs during power-up so
  // a tone already present is flagged as soon as power-up ends
  wire logic det_diff = tone_s != est_r;
  wire logic det_full = est_r ? (det_cnt_r >= 21'(ABS_CYC - 1)) : (det_cnt_r >= 21'(DET_CYC - 1));
  wire logic est_rise = !est_r && det_diff && det_full && ready_r;
  wire logic est_fall = est_r && det_diff && det_full;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      det_cnt_r <= 21'h000000;
      est_r <= 1'b0;
    end else if (pd_s) begin
      det_cnt_r <= 21'h000000;
      est_r <= 1'b0;
    end else if (!det_diff || est_rise || est_fall) begin
      det_cnt_r <= 21'h000000;
      est_r <= est_rise ? 1'b1 : (est_fall ? 1'b0 : est_r);
    end else if (!det_full) begin
      det_cnt_r <= det_cnt_r + 21'h000001;
    end
  end

  // Qualification source: returned pin level in external mode
  wire logic qual = ext_mode ? pin_s : est_r;
  wire logic pg_done = gcnt_r >= pguard_r;
  wire logic ag_done = gcnt_r >= aguard_r;

  // Steering state machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      tsl_pkg::ST_IDLE: begin
        if (qual) begin
          state_nxt = tsl_pkg::ST_PGUARD;
        end
      end
      tsl_pkg::ST_PGUARD: begin
        if (!qual) begin
          state_nxt = tsl_pkg::ST_IDLE;
        end else if (pg_done) begin
          state_nxt = tsl_pkg::ST_LOAD;
        end
      end
      tsl_pkg::ST_LOAD: begin
        state_nxt = tsl_pkg::ST_VALID;
      end
      tsl_pkg::ST_VALID: begin
        if (!qual) begin
          state_nxt = tsl_pkg::ST_AGUARD;
        end
      end
      tsl_pkg::ST_AGUARD: begin
        if (qual) begin
          state_nxt = tsl_pkg::ST_VALID;
        end else if (ag_done) begin
          state_nxt = tsl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = tsl_pkg::ST_IDLE;
      end
    endcase
  end

  wire logic st_change = state_nxt != state_r;
  wire logic do_latch = state_r == tsl_pkg::ST_PGUARD && state_nxt == tsl_pkg::ST_LOAD;
  wire logic valid_nxt = state_nxt == tsl_pkg::ST_VALID || state_nxt == tsl_pkg::ST_AGUARD;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= tsl_pkg::ST_IDLE;
      gcnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      gcnt_r <= st_change ? 16'h0000 : (tick_r && gcnt_r != 16'hFFFF ? gcnt_r + 16'h0001 : gcnt_r);
    end
  end

  // Code latch is independent of the output enable
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      code_r <= 4'h0;
      valid_r <= 1'b0;
    end else begin
      if (do_latch) begin
        code_r <= code_s;
      end
      valid_r <= valid_nxt;
    end
  end

  // Pin drivers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      drv_r <= 1'b0;
      drv_oe_r <= 1'b0;
      code_oe_r <= 1'b0;
    end else begin
      drv_r <= est_r;
      drv_oe_r <= ext_mode;
      code_oe_r <= toe_s;
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  wire logic [3:0] ev_set = {state_r == tsl_pkg::ST_PGUARD && state_nxt == tsl_pkg::ST_IDLE,
                             est_rise,
                             state_r == tsl_pkg::ST_AGUARD && state_nxt == tsl_pkg::ST_IDLE,
                             do_latch};
  wire logic [3:0] st_clr = (reg_wr_in && sel_status) ? reg_wdata_in[3:0] : 4'h0;
  wire logic [3:0] status_nxt = (status_r & ~st_clr) | ev_set;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r <= `TSL_CTRL_RST;
      pguard_r <= `TSL_PGUARD_RST;
      aguard_r <= `TSL_AGUARD_RST;
      mask_r <= `TSL_MASK_RST;
    end else if (reg_wr_in) begin
      if (sel_ctrl) begin
        ctrl_r <= {15'h0000, reg_wdata_in[`TSL_CTRL_EXT]};
      end
      if (sel_pguard) begin
        pguard_r <= reg_wdata_in;
      end
      if (sel_aguard) begin
        aguard_r <= reg_wdata_in;
      end
      if (sel_mask) begin
        mask_r <= reg_wdata_in[3:0];
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      status_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // Read mux; unmapped addresses read zero
  wire logic [15:0] state_word = {3'h0, state_r, ready_r, est_r, valid_r, toe_s, code_r};
  wire logic [15:0] rd_mux = sel_ctrl ? ctrl_r :
                             sel_pguard ? pguard_r :
                             sel_aguard ? aguard_r :
                             sel_status ? {12'h000, status_r} :
                             sel_mask ? {12'h000, mask_r} :
                             sel_state ? state_word : 16'h0000;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

  assign early_tone_flag_out = est_r;
  assign digit_valid_flag_out = valid_r;
  assign digit_code_bus_out = code_r;
  assign digit_code_oe_out = code_oe_r;
  assign steer_guard_out = drv_r;
  assign steer_guard_oe_out = drv_oe_r;
  assign reg_rdata_out = rdata_r;
  assign irq_out = irq_r;

  // Checks
  property p_code_before_flag;
    @(posedge clock_in) disable iff (rst_in)
      $rose(valid_r) |-> $past(state_r) == tsl_pkg::ST_LOAD && $stable(code_r);
  endproperty
  a_code_before_flag: assert property (p_code_before_flag) else $error("valid rose without prior code load");

  property p_short_tone;
    @(posedge clock_in) disable iff (rst_in)
      (state_r == tsl_pkg::ST_PGUARD && !qual) |=> state_r == tsl_pkg::ST_IDLE && $stable(code_r) && !valid_r;
  endproperty
  a_short_tone: assert property (p_short_tone) else $error("short tone changed outputs");

  property p_latch;
    @(posedge clock_in) disable iff (rst_in)
      do_latch |=> code_r == $past(code_s) ##1 valid_r;
  endproperty
  a_latch: assert property (p_latch) else $error("qualified code not latched");

  property p_hold;
    @(posedge clock_in) disable iff (rst_in)
      (state_r == tsl_pkg::ST_IDLE || state_r == tsl_pkg::ST_AGUARD) |=> $stable(code_r);
  endproperty
  a_hold: assert property (p_hold) else $error("code changed without qualification");

  property p_dropout;
    @(posedge clock_in) disable iff (rst_in)
      (state_r == tsl_pkg::ST_AGUARD && qual) |=> state_r == tsl_pkg::ST_VALID && valid_r && $stable(code_r);
  endproperty
  a_dropout: assert property (p_dropout) else $error("dropout ended the digit");

  property p_flag_fall;
    @(posedge clock_in) disable iff (rst_in)
      $fell(valid_r) |-> $past(state_r) == tsl_pkg::ST_AGUARD && $past(ag_done) && !$past(qual);
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("valid fell before absent guard");

  property p_enable;
    @(posedge clock_in) disable iff (rst_in)
      !toe_s |=> !digit_code_oe_out;
  endproperty
  a_enable: assert property (p_enable) else $error("outputs driven while disabled");

  // Latch must not depend on the enable, or a re-enabled bus shows a stale digit
  property p_hidden_latch;
    @(posedge clock_in) disable iff (rst_in)
      (!code_oe_r && do_latch) |=> code_r == $past(code_s);
  endproperty
  a_hidden_latch: assert property (p_hidden_latch) else $error("digit not latched while disabled");

  property p_early_rise;
    @(posedge clock_in) disable iff (rst_in)
      $rose(est_r) |-> $past(tone_s) && $past(det_cnt_r) >= 21'(DET_CYC - 1) && $past(ready_r);
  endproperty
  a_early_rise: assert property (p_early_rise) else $error("early flag rose too soon");

  property p_early_fall;
    @(posedge clock_in) disable iff (rst_in)
      ($fell(est_r) && !$past(pd_s)) |-> !$past(tone_s) && $past(det_cnt_r) >= 21'(ABS_CYC - 1);
  endproperty
  a_early_fall: assert property (p_early_fall) else $error("early flag fell too soon");

  property p_powerdown;
    @(posedge clock_in) disable iff (rst_in)
      pd_s |=> !est_r && !ready_r;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("early flag during power-down");

  property p_guard_drive;
    @(posedge clock_in) disable iff (rst_in)
      ext_mode |=> steer_guard_oe_out && steer_guard_out == $past(est_r);
  endproperty
  a_guard_drive: assert property (p_guard_drive) else $error("guard pin not driven with early flag");

  property p_set_wins;
    @(posedge clock_in) disable iff (rst_in)
      ev_set[0] |=> status_r[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("latch event lost in status");

  // One cycle of lag after a mask write is accepted
  property p_irq_level;
    @(posedge clock_in) disable iff (rst_in)
      $stable(mask_r) |-> irq_out == |(status_r & mask_r);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

endmodule

// ===== include/tsl_consts.svh
`ifndef TSL_CONSTS_SVH
`define TSL_CONSTS_SVH

// Clock
`define TSL_CLK_NS 20

// Detection and power-up times
`define TSL_DET_MIN_MS 5
`define TSL_DET_MAX_MS 14
`define TSL_ABS_MIN_US 500
`define TSL_ABS_MAX_US 8500
`define TSL_PWRUP_MS 30
`define TSL_TICK_US 100

// Derived cycle counts, least times rounded up
`define TSL_DET_CYC ((`TSL_DET_MIN_MS * 1000000 + `TSL_CLK_NS - 1) / `TSL_CLK_NS)
`define TSL_ABS_CYC ((`TSL_ABS_MIN_US * 1000 + `TSL_CLK_NS - 1) / `TSL_CLK_NS)
`define TSL_PWRUP_CYC ((`TSL_PWRUP_MS * 1000000 + `TSL_CLK_NS - 1) / `TSL_CLK_NS)
`define TSL_TICK_CYC ((`TSL_TICK_US * 1000 + `TSL_CLK_NS - 1) / `TSL_CLK_NS)

// Register offsets
`define TSL_REG_CTRL 8'h00
`define TSL_REG_PGUARD 8'h04
`define TSL_REG_AGUARD 8'h08
`define TSL_REG_STATUS 8'h0C
`define TSL_REG_MASK 8'h10
`define TSL_REG_STATE 8'h14

// Reset values, guard counts in 0.1 ms ticks
`define TSL_CTRL_RST 16'h0000
`define TSL_PGUARD_RST 16'h00FA
`define TSL_AGUARD_RST 16'h0096
`define TSL_MASK_RST 4'h0

// Field positions
`define TSL_CTRL_EXT 0
`define TSL_ST_LATCH 0
`define TSL_ST_END 1
`define TSL_ST_EARLY 2
`define TSL_ST_REJECT 3

`endif

// ===== include/tsl_pkg.sv
package tsl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PGUARD = 5'h02,
    ST_LOAD = 5'h04,
    ST_VALID = 5'h08,
    ST_AGUARD = 5'h10
  } tsl_state_e;
endpackage
